//--- hw/ioc_pkg.sv
// constants shared by the change-compare block and its pin cells
package ioc_pkg;
   // -------------------------------------------------------------
   // register addresses (pointer values)
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_DIRECTION = 8'h00; // owned outside
   localparam logic [7:0] ADDR_CHANGE_EN = 8'h02; // owned outside
   localparam logic [7:0] ADDR_DEFAULT = 8'h03; // default_compare_value
   localparam logic [7:0] ADDR_SELECT = 8'h04; // compare_source_select
   localparam logic [7:0] ADDR_CONFIG = 8'h05; // expander_configuration
   localparam logic [7:0] ADDR_FLAGS = 8'h07; // per-pin cause flags
   localparam logic [7:0] ADDR_CAPTURE = 8'h08; // captured_value_register
   localparam logic [7:0] ADDR_PORT = 8'h09; // port value
   localparam logic [7:0] ADDR_LAST = 8'h0a; // pointer wraps after this
   // -------------------------------------------------------------
   // expander_configuration fields
   // -------------------------------------------------------------
   localparam int SEQ_OP_BIT = 5; // sequential_operation_bit
   localparam int OPEN_DRAIN_BIT = 2; // open_drain_select
   localparam int POLARITY_BIT = 1; // irq_polarity_bit
   localparam int CLEAR_CTRL_BIT = 0; // irq_clear_control
   localparam logic [7:0] CONFIG_MASK = 8'h27; // implemented bits only
   // -------------------------------------------------------------
   // values after reset
   // -------------------------------------------------------------
   localparam logic [7:0] DEFAULT_RST = 8'h00;
   localparam logic [7:0] SELECT_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] CAPTURE_RST = 8'h00;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic INT_LEVEL_RST = 1'b1; // push-pull low-active, idle high
   localparam logic INT_OE_RST = 1'b1;
endpackage

//--- hw/ioc_pin_cell.sv
// one pin: synchroniser, previous-value reference and mismatch detect
`timescale 1ns/1ps
module ioc_pin_cell
   import ioc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // pin and compare setup
   input wire logic pin_in,
   input wire logic use_default_in,
   input wire logic default_bit_in,
   input wire logic hold_in,
   // results
   output logic level_out,
   output logic mismatch_out
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic sync1; // first stage, read only by sync2
      logic sync2; // clean pin level
      logic prev; // previous-value reference
   } cell_t;

   cell_t cell_r; // registered state
   cell_t cell_nxt; // next state

   // next state and compare
   always_comb
   begin
      cell_nxt = cell_r;
      cell_nxt.sync1 = pin_in;
      cell_nxt.sync2 = cell_r.sync1;
      // reference follows pin, frozen while pending
      if (!hold_in)
      begin
         cell_nxt.prev = cell_r.sync2;
      end
      if (use_default_in)
      begin
         mismatch_out = cell_r.sync2 != default_bit_in;
      end
      else
      begin
         mismatch_out = cell_r.sync2 != cell_r.prev;
      end
      level_out = cell_r.sync2;
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cell_r <= '0;
      end
      else
      begin
         cell_r <= cell_nxt;
      end
   end
endmodule // ioc_pin_cell

//--- hw/ioc_compare_and_config.sv
// change-compare interrupt logic with its configuration registers
// Contract
// - default mode flags pin opposite default bit
// - select bit 1 default, 0 previous
// - pointer increments unless sequential bit set
// - open-drain select drives open-drain output
// - push-pull polarity follows polarity bit
// - clear-control picks capture or port read
// - clear only when mismatch condition inactive
// - config bits 7,6,4,3 read zero
// - only enabled pins take part
// - output pins never cause interrupt
// - first event captures, later ones wait
// - clear after lsb out, writes ignored
`timescale 1ns/1ps
module ioc_compare_and_config
   import ioc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // port pins
   input wire logic [7:0] pins_in,
   // settings held in registers outside this block
   input wire logic [7:0] change_irq_enable_in,
   input wire logic [7:0] pin_direction_in,
   // register port from the serial engine
   input wire logic ptr_load_in,
   input wire logic [7:0] ptr_addr_in,
   input wire logic byte_done_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   input wire logic read_lsb_done_in,
   // register answers
   output logic [7:0] reg_ptr_out,
   output logic [7:0] reg_rdata_out,
   output logic [7:0] irq_flags_out,
   // interrupt pin
   output logic int_level_out,
   output logic int_oe_out
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ptr; // register address pointer
      logic [7:0] default_bits; // default_compare_value
      logic [7:0] compare_select_bits; // compare_source_select
      logic [7:0] config_bits; // expander_configuration
      logic [7:0] flags; // which pins caused the interrupt
      logic [7:0] captured; // captured_value_register
      logic [7:0] rdata; // read answer
      logic pending; // interrupt active
      logic int_level; // pin level
      logic int_oe; // pin drive enable
   } state_t;

   localparam state_t STATE_RST = '{
      ptr: PTR_RST, default_bits: DEFAULT_RST, compare_select_bits: SELECT_RST,
      config_bits: CONFIG_RST, flags: 8'h00, captured: CAPTURE_RST,
      rdata: 8'h00, pending: 1'b0, int_level: INT_LEVEL_RST, int_oe: INT_OE_RST};

   state_t st_r; // registered state
   state_t st_nxt; // next state

   logic [7:0] levels; // synchronised pin levels
   logic [7:0] mismatch; // raw per-pin mismatch
   logic [7:0] armed; // pins allowed to interrupt
   logic [7:0] active; // armed mismatches
   logic condition; // any armed mismatch
   logic clear_read; // selected register read finished
   logic clear_ok; // clear accepted

   // -------------------------------------------------------------
   // per-pin compare cells
   // -------------------------------------------------------------
   for (genvar i = 0; i < 8; i++)
   begin : g_pin
      ioc_pin_cell u_cell (
         .clk_in(clk_in),
         .rst_in(rst_in),
         .pin_in(pins_in[i]),
         .use_default_in(st_r.compare_select_bits[i]),
         .default_bit_in(st_r.default_bits[i]),
         .hold_in(st_r.pending),
         .level_out(levels[i]),
         .mismatch_out(mismatch[i])
      );
   end

   // -------------------------------------------------------------
   // interrupt condition and clear decode
   // -------------------------------------------------------------
   always_comb
   begin
      armed = change_irq_enable_in & pin_direction_in;
      active = mismatch & armed;
      condition = |active;
      // clearing register chosen by clear control
      if (st_r.config_bits[CLEAR_CTRL_BIT])
      begin
         clear_read = read_lsb_done_in && (st_r.ptr == ADDR_CAPTURE);
      end
      else
      begin
         clear_read = read_lsb_done_in && (st_r.ptr == ADDR_PORT);
      end
      clear_ok = clear_read && !condition;
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      // pointer load or advance
      if (ptr_load_in)
      begin
         st_nxt.ptr = ptr_addr_in;
      end
      else if (byte_done_in && !st_r.config_bits[SEQ_OP_BIT])
      begin
         if (st_r.ptr == ADDR_LAST)
         begin
            st_nxt.ptr = PTR_RST;
         end
         else
         begin
            st_nxt.ptr = st_r.ptr + 8'h01;
         end
      end
      // register writes at the pointer
      if (reg_wr_in)
      begin
         if (st_r.ptr == ADDR_DEFAULT)
         begin
            st_nxt.default_bits = reg_wdata_in;
         end
         else if (st_r.ptr == ADDR_SELECT)
         begin
            st_nxt.compare_select_bits = reg_wdata_in;
         end
         else if (st_r.ptr == ADDR_CONFIG)
         begin
            st_nxt.config_bits = reg_wdata_in & CONFIG_MASK;
         end
      end
      // register reads at the pointer
      if (reg_rd_in)
      begin
         if (st_r.ptr == ADDR_DEFAULT)
         begin
            st_nxt.rdata = st_r.default_bits;
         end
         else if (st_r.ptr == ADDR_SELECT)
         begin
            st_nxt.rdata = st_r.compare_select_bits;
         end
         else if (st_r.ptr == ADDR_CONFIG)
         begin
            st_nxt.rdata = st_r.config_bits & CONFIG_MASK;
         end
         else if (st_r.ptr == ADDR_FLAGS)
         begin
            st_nxt.rdata = st_r.flags;
         end
         else if (st_r.ptr == ADDR_CAPTURE)
         begin
            st_nxt.rdata = st_r.captured;
         end
         else if (st_r.ptr == ADDR_PORT)
         begin
            st_nxt.rdata = levels;
         end
         else
         begin
            // held by other blocks or unmapped
            st_nxt.rdata = 8'h00;
         end
      end
      // first event captures, later ones wait
      if (!st_r.pending && condition)
      begin
         st_nxt.pending = 1'b1;
         st_nxt.captured = levels;
         st_nxt.flags = active;
      end
      else if (st_r.pending && clear_ok)
      begin
         st_nxt.pending = 1'b0;
         st_nxt.flags = 8'h00;
      end
      if (st_nxt.config_bits[OPEN_DRAIN_BIT])
      begin
         st_nxt.int_oe = st_nxt.pending;
         st_nxt.int_level = 1'b0;
      end
      else
      begin
         st_nxt.int_oe = 1'b1;
         st_nxt.int_level = ~(st_nxt.pending ^ st_nxt.config_bits[POLARITY_BIT]);
      end
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_r <= STATE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   assign reg_ptr_out = st_r.ptr;
   assign reg_rdata_out = st_r.rdata;
   assign irq_flags_out = st_r.flags;
   assign int_level_out = st_r.int_level;
   assign int_oe_out = st_r.int_oe;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_default_mismatch_hit: assert property (
      (st_r.compare_select_bits[0] && armed[0] && levels[0] != st_r.default_bits[0]
       && !st_r.pending) |=> st_r.pending)
      else $error("default mismatch did not raise interrupt");
   a_select_source_used: assert property (
      st_r.compare_select_bits[0] |-> (mismatch[0] == (levels[0] != st_r.default_bits[0])))
      else $error("compare source not honoured");
   a_ptr_increment: assert property (
      (byte_done_in && !ptr_load_in && !st_r.config_bits[SEQ_OP_BIT]
       && st_r.ptr != ADDR_LAST) |=> st_r.ptr == $past(st_r.ptr) + 8'h01)
      else $error("pointer did not advance");
   a_ptr_fixed: assert property (
      (byte_done_in && !ptr_load_in && st_r.config_bits[SEQ_OP_BIT]) |=> $stable(st_r.ptr))
      else $error("pointer moved with sequential bit set");
   a_open_drain_pin: assert property (
      st_r.config_bits[OPEN_DRAIN_BIT] |-> (int_oe_out == st_r.pending && !int_level_out))
      else $error("open-drain drive wrong");
   a_push_pull_pin: assert property (
      !st_r.config_bits[OPEN_DRAIN_BIT] |->
      (int_oe_out && int_level_out == (st_r.pending == st_r.config_bits[POLARITY_BIT])))
      else $error("push-pull level wrong");
   a_clear_needs_idle: assert property (
      $fell(st_r.pending) |-> $past(clear_ok))
      else $error("interrupt cleared without idle condition");
   a_reserved_zero: assert property (
      (st_r.config_bits & ~CONFIG_MASK) == 8'h00)
      else $error("unimplemented config bit stored");
   a_outputs_ignored: assert property (
      (!st_r.pending && armed == 8'h00) |=> !st_r.pending)
      else $error("disabled or output pin raised interrupt");
   a_capture_hold: assert property (
      (st_r.pending && !clear_ok) |=> (st_r.pending && $stable(st_r.captured)))
      else $error("capture changed while pending");
   a_capture_value: assert property (
      (!st_r.pending && condition) |=> st_r.captured == $past(levels))
      else $error("capture missed port value");
   a_write_no_clear: assert property (
      (st_r.pending && !read_lsb_done_in) |=> st_r.pending)
      else $error("interrupt cleared without read");

   c_event_raised: cover property (!st_r.pending ##1 st_r.pending);
   c_clear_capture: cover property (st_r.pending && clear_ok && st_r.config_bits[0]);
   c_clear_refused: cover property (st_r.pending && clear_read && condition);
   c_open_drain_active: cover property (st_r.config_bits[OPEN_DRAIN_BIT] && int_oe_out);
endmodule // ioc_compare_and_config

//--- tb/ioc_host_model.sv
// serial-engine stand-in that issues single-byte register transfers
`timescale 1ns/1ps
module ioc_host_model
(
   // clock and read answer
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   // register port strobes
   output logic ptr_load_out,
   output logic [7:0] ptr_addr_out,
   output logic byte_done_out,
   output logic reg_wr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_rd_out,
   output logic lsb_done_out
);
   // ----------------------------------------
   // idle port at time zero
   // ----------------------------------------
   initial
   begin
      ptr_load_out = 1'b0;
      ptr_addr_out = 8'h00;
      byte_done_out = 1'b0;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
      reg_rd_out = 1'b0;
      lsb_done_out = 1'b0;
   end
   // ----------------------------------------
   // one byte: load pointer, access, end byte
   // ----------------------------------------
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge clk_in);
      ptr_load_out = 1'b1;
      ptr_addr_out = a;
      @(negedge clk_in);
      ptr_load_out = 1'b0;
      ptr_addr_out = ~a; // released bus shows no stale value
      reg_wr_out = wr;
      reg_wdata_out = wr ? d : ~d;
      reg_rd_out = !wr;
      @(negedge clk_in);
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = ~d;
      q = rdata_in;
      lsb_done_out = !wr;
      byte_done_out = 1'b1;
      @(negedge clk_in);
      lsb_done_out = 1'b0;
      byte_done_out = 1'b0;
   endtask
endmodule // ioc_host_model

//--- tb/tb.sv
// bench for the change-compare block and its registers
`timescale 1ns/1ps
module tb;
   import ioc_pkg::*;
   // ----------------------------------------
   // clock, reset and wiring
   // ----------------------------------------
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] pins = 8'h00; // pin levels
   logic [7:0] ien = 8'h00; // change enables
   logic [7:0] dir = 8'hff; // 1 = input
   logic pl, bd, wr, rd, ld, lvl, oe;
   logic [7:0] pa, wd, ptr, rdat, flags, q;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #10 clk_in = ~clk_in;
   ioc_host_model host_u (.clk_in(clk_in), .rdata_in(rdat), .ptr_load_out(pl),
      .ptr_addr_out(pa), .byte_done_out(bd), .reg_wr_out(wr), .reg_wdata_out(wd),
      .reg_rd_out(rd), .lsb_done_out(ld));
   ioc_compare_and_config dut_u (.clk_in(clk_in), .rst_in(rst_in), .pins_in(pins),
      .change_irq_enable_in(ien), .pin_direction_in(dir), .ptr_load_in(pl),
      .ptr_addr_in(pa), .byte_done_in(bd), .reg_wr_in(wr), .reg_wdata_in(wd),
      .reg_rd_in(rd), .read_lsb_done_in(ld), .reg_ptr_out(ptr), .reg_rdata_out(rdat),
      .irq_flags_out(flags), .int_level_out(lvl), .int_oe_out(oe));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host_u.xfer(a, 1'b0, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      host_u.xfer(a, 1'b1, d, q);
   endtask
   // interrupt pin as {drive enable, level}
   task automatic pinc(input logic [1:0] e);
      chk("int pin", {6'h00, e}, {6'h00, oe, lvl});
   endtask
   // two sync cycles, one for the event to land, one spare
   task automatic settle;
      repeat (4) @(negedge clk_in);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("ptr", 8'h00, ptr);
      pinc(2'b11);
      rdc(ADDR_DEFAULT, 8'h00);
      rdc(ADDR_SELECT, 8'h00);
      rdc(ADDR_CONFIG, 8'h00);
   endtask
   task automatic t_regs;
      wreg(ADDR_DEFAULT, 8'ha5);
      wreg(ADDR_SELECT, 8'h5a);
      wreg(ADDR_CONFIG, 8'hdb);
      rdc(ADDR_DEFAULT, 8'ha5);
      rdc(ADDR_SELECT, 8'h5a);
      rdc(ADDR_CONFIG, 8'h03);
      wreg(ADDR_DEFAULT, 8'h00);
      wreg(ADDR_SELECT, 8'h00);
   endtask
   // sequential bit stops the pointer at the byte end
   task automatic t_ptr;
      wreg(ADDR_CONFIG, 8'h20);
      chk("ptr", ADDR_CONFIG, ptr);
      wreg(ADDR_CONFIG, 8'h00);
      chk("ptr", 8'h06, ptr);
      // unmapped last address reads zero, pointer wraps
      rdc(ADDR_LAST, 8'h00);
      chk("ptr wrap", PTR_RST, ptr);
   endtask
   // previous-value mode, active-low push-pull, clear on port read
   task automatic t_prev;
      ien = 8'h05;
      dir = 8'hfb;
      pins = 8'h06;
      settle;
      pinc(2'b11);
      pins = 8'h07;
      settle;
      pinc(2'b10);
      chk("flags", 8'h01, flags);
      rdc(ADDR_FLAGS, 8'h01);
      pins = 8'h06;
      settle;
      rdc(ADDR_CAPTURE, 8'h07);
      rdc(ADDR_PORT, 8'h06);
      pinc(2'b10);
      pins = 8'h07;
      settle;
      wreg(ADDR_PORT, 8'h00);
      pinc(2'b10);
      rdc(ADDR_PORT, 8'h07);
      pinc(2'b11);
      chk("flags", 8'h00, flags);
   endtask
   // default mode, active-high then open-drain, clear on capture read
   task automatic t_default;
      wreg(ADDR_DEFAULT, 8'h01);
      wreg(ADDR_SELECT, 8'h01);
      wreg(ADDR_CONFIG, 8'h03);
      pinc(2'b10);
      pins = 8'h06;
      settle;
      pinc(2'b11);
      wreg(ADDR_CONFIG, 8'h07);
      pinc(2'b10);
      rdc(ADDR_PORT, 8'h06);
      pinc(2'b10);
      pins = 8'h07;
      settle;
      rdc(ADDR_CAPTURE, 8'h06);
      pinc(2'b00);
   endtask
   // ----------------------------------------
   // verdict and hang guard
   // ----------------------------------------
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         err_total++;
         complete_run;
      end
   end
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge clk_in);
      t_reset;
      t_regs;
      t_ptr;
      t_prev;
      t_default;
      complete_run;
   end
endmodule // tb
